//--- dv/jhc_station_model.sv
// Station transmit model: sends one frame of drive on request
`timescale 1ns/1ps
module jhc_station_model
(
   input wire logic ref_clk,
   input wire logic start,
   input wire logic [7:0] len,
   input wire logic tx_enabled,
   output logic tx_below,
   output logic tx_data,
   output logic busy
);
   logic [7:0] left_ff = 8'h00;
   // Frame countdown; no frame starts while transmit is held off
   always @(posedge ref_clk)
   begin
      if (start && !busy && tx_enabled)
         left_ff <= len;
      else if (busy)
         left_ff <= left_ff - 8'h01;
   end
   // Idle line parks above squelch so the transmitter can end the frame
   assign busy = (left_ff != 8'h00);
   assign tx_below = busy;
   assign tx_data = busy ? left_ff[0] : 1'b1;
endmodule

//--- dv/jhc_top_sva.sv
// Checker for the jabber, heartbeat and collision block
`timescale 1ns/1ps
module jhc_top_sva
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Inputs
   input wire jhc_pkg::jhc_levels_t levels,
   input wire logic rx_data,
   input wire logic heartbeat_enable,
   // Outputs
   input wire logic coax_transmit_en,
   input wire logic rx_out_p,
   input wire logic rx_out_n,
   input wire logic collision_out_pair_p,
   input wire logic collision_out_pair_n,
   input wire jhc_pkg::jhc_status_t status
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Any reason to drive the collision pair
   wire logic act = status.collision | status.jabber | status.heartbeat;
   // Transmit end without a fault, and a burst of minimum length
   sequence s_tx_end;
      $fell(coax_transmit_en) && !status.jabber;
   endsequence
   sequence s_burst;
      status.heartbeat[*8];
   endsequence
   property p_hb_start;
      s_tx_end ##0 !heartbeat_enable |-> ##[9:14] status.heartbeat;
   endproperty
   property p_hb_len;
      $rose(status.heartbeat) |-> s_burst ##[1:4] !status.heartbeat;
   endproperty
   property p_hb_none;
      s_tx_end ##0 heartbeat_enable |=> !status.heartbeat[*8] ##1 !status.heartbeat[*8];
   endproperty
   property p_cd_idle;
      !act[*3] |-> !collision_out_pair_p && !collision_out_pair_n;
   endproperty
   property p_cd_tog;
      act[*3] |-> collision_out_pair_p != $past(collision_out_pair_p)
         && collision_out_pair_p != collision_out_pair_n;
   endproperty
   property p_jab_tx;
      status.jabber[*2] |-> !coax_transmit_en;
   endproperty
   property p_unjab;
      !status.tx_enabled[*2] |-> !coax_transmit_en;
   endproperty
   property p_coll;
      levels.coll_detect[*2] |-> status.collision;
   endproperty
   property p_rx_idle;
      !status.rx_active[*2] |-> !rx_out_p && !rx_out_n;
   endproperty
   property p_rx_off;
      status.rx_active ##0 rx_data[*3] |=> !status.rx_active;
   endproperty
   property p_tx_off;
      !levels.tx_below_squelch[*6] |-> !coax_transmit_en;
   endproperty
   a_hb_start: assert property (p_hb_start) else $error("late heartbeat");
   a_hb_len: assert property (p_hb_len) else $error("short burst");
   a_hb_none: assert property (p_hb_none) else $error("burst when off");
   a_cd_idle: assert property (p_cd_idle) else $error("pair not idle");
   a_cd_tog: assert property (p_cd_tog) else $error("pair not toggling");
   a_jab_tx: assert property (p_jab_tx) else $error("tx during fault");
   a_unjab: assert property (p_unjab) else $error("tx during unjab");
   a_coll: assert property (p_coll) else $error("collision missed");
   a_rx_idle: assert property (p_rx_idle) else $error("rx pair not idle");
   a_rx_off: assert property (p_rx_off) else $error("no quick off");
   a_tx_off: assert property (p_tx_off) else $error("tx stuck on");
endmodule
bind jhc_top jhc_top_sva u_jhc_top_sva (.ref_clk, .rst, .levels, .rx_data, .heartbeat_enable,
   .coax_transmit_en, .rx_out_p, .rx_out_n, .collision_out_pair_p, .collision_out_pair_n,
   .status);

//--- dv/jhc_top_tb_top.sv
// Self-checking bench for the jabber, heartbeat and collision block
`timescale 1ns/1ps
module jhc_top_tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic rx_below = 1'b0;
   logic coll = 1'b0;
   logic rx_data = 1'b1;
   logic heartbeat_enable = 1'b0;
   logic start = 1'b0;
   logic tx_below, tx_data, busy, tx_o, tx_en, rp, rn, cp, cn;
   jhc_pkg::jhc_levels_t levels;
   jhc_pkg::jhc_status_t status;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   assign levels = {tx_below, rx_below, 1'b0, coll};
   always #50 ref_clk = ~ref_clk;
   jhc_top u_jhc_top (.ref_clk(ref_clk), .rst(rst), .levels(levels), .tx_data(tx_data),
      .rx_data(rx_data), .heartbeat_enable(heartbeat_enable), .coax_transmit_out(tx_o),
      .coax_transmit_en(tx_en), .rx_out_p(rp), .rx_out_n(rn), .collision_out_pair_p(cp),
      .collision_out_pair_n(cn), .status(status));
   jhc_station_model u_jhc_station_model (.ref_clk(ref_clk), .start(start), .len(8'h14),
      .tx_enabled(status.tx_enabled), .tx_below(tx_below), .tx_data(tx_data), .busy(busy));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Frame then heartbeat, timed from the end of transmit
   task automatic t_frame(input logic hb_off);
      int n;
      int w;
      logic last;
      @(posedge ref_clk) heartbeat_enable <= hb_off;
      start <= 1'b1;
      @(posedge ref_clk) start <= 1'b0;
      repeat (5) @(negedge ref_clk);
      chk("tx_en", 16'h1, tx_en);
      // Drive repeats station data one clock later
      repeat (2)
      begin
         last = tx_data;
         @(negedge ref_clk);
         chk("tx_out", {15'h0, last}, tx_o);
      end
      w = 0;
      while (busy === 1'b1 && w < 40) begin @(negedge ref_clk); w++; end
      n = 0;
      while (tx_en === 1'b1 && n < 20) begin @(negedge ref_clk); n++; end
      chk("tx_off", 16'h1, n >= jhc_pkg::TX_OFF_CYC && n <= jhc_pkg::TX_OFF_CYC + 2);
      w = 0;
      n = 0;
      repeat (30) begin @(negedge ref_clk); n += (n > 0 || status.heartbeat === 1'b1); w++; end
      if (hb_off)
         chk("hb_off", 16'h0, n);
      else
         chk("hb_delay", 16'h1, n >= 8 && n <= 21);
      repeat (10) @(negedge ref_clk);
      chk("cd_idle", 16'h0, {cp, cn});
   endtask
   // Burst width and differential drive of the collision pair during it
   task automatic t_burst();
      int n;
      @(posedge ref_clk) heartbeat_enable <= 1'b0;
      start <= 1'b1;
      @(posedge ref_clk) start <= 1'b0;
      while (status.heartbeat !== 1'b1 && cyc < 2900) @(negedge ref_clk);
      repeat (3) @(negedge ref_clk);
      chk("cd_diff", 16'h1, cp !== cn);
      n = 3;
      while (status.heartbeat === 1'b1 && n < 40) begin @(negedge ref_clk); n++; end
      chk("hb_len", 16'h1, n >= jhc_pkg::HB_LEN_CYC && n <= jhc_pkg::HB_LEN_CYC + 2);
      chk("jabber", 16'h0, status.jabber);
   endtask
   // Collision input: pair toggles every clock, idles afterwards
   task automatic t_coll();
      int n;
      logic last;
      @(posedge ref_clk) coll <= 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("coll", 16'h1, status.collision);
      n = 0;
      last = cp;
      repeat (10) begin @(negedge ref_clk); n += (cp !== last); last = cp; end
      chk("cd_tog", 16'hA, n);
      @(posedge ref_clk) coll <= 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("cd_rest", 16'h0, {cp, cn});
   endtask
   // Receive squelch: on, quick off, resume, then stay off
   task automatic t_rx();
      @(posedge ref_clk) rx_below <= 1'b1;
      rx_data <= 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("rx_on", 16'h1, status.rx_active);
      chk("rx_pair", 16'h1, {rp, rn});
      @(posedge ref_clk) rx_data <= 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("rx_quick_off", 16'h0, status.rx_active);
      @(posedge ref_clk) rx_data <= 1'b0;
      repeat (14) @(negedge ref_clk);
      chk("rx_resume", 16'h1, status.rx_active);
      @(posedge ref_clk) rx_data <= 1'b1;
      repeat (4) @(negedge ref_clk);
      @(posedge ref_clk) rx_below <= 1'b0;
      repeat (15) @(negedge ref_clk);
      chk("rx_stay_off", 16'h0, status.rx_active);
      chk("rx_idle", 16'h0, {rp, rn});
   endtask
   // Cycle ceiling well above the few hundred cycles the run needs
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         report_and_stop();
      end
   end
   // Main sequence
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      chk("tx_enabled", 16'h1, status.tx_enabled);
      t_frame(1'b0);
      t_frame(1'b1);
      t_burst();
      t_coll();
      t_rx();
      report_and_stop();
   end
endmodule

//--- src/jhc_down_timer.sv
// Loadable down counter that reports expiry
`timescale 1ns/1ps
module jhc_down_timer #(parameter int unsigned W = 8)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Control
   input wire logic load,
   input wire logic [W-1:0] load_val,
   // Status
   output logic expired
);
   logic [W-1:0] cnt_ff;

   // Counts down to zero and rests there
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         cnt_ff <= '0;
      else if (load)
         cnt_ff <= load_val;
      else if (cnt_ff != '0)
         cnt_ff <= cnt_ff - 1'b1;
   end

   assign expired = (cnt_ff == '0);
endmodule

//--- src/jhc_osc_gate.sv
// Gates a 5 MHz square wave (half the 10 MHz clock) onto a differential pair with zero idle
`timescale 1ns/1ps
module jhc_osc_gate
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Control
   input wire logic enable,
   // Pair outputs
   output logic pair_p,
   output logic pair_n
);
   logic phase_ff;
   logic en_ff;

   // Square wave toggles each rising edge; half rate is the best one clock allows
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         phase_ff <= 1'b0;
         en_ff <= 1'b0;
      end
      else
      begin
         phase_ff <= enable ? ~phase_ff : 1'b0;
         en_ff <= enable;
      end
   end

   // Both legs low when idle gives zero differential
   assign pair_p = en_ff & phase_ff;
   assign pair_n = en_ff & ~phase_ff;
endmodule

//--- src/jhc_pkg.sv
// Package with constants and carrier types for the jabber, heartbeat and collision logic
package jhc_pkg;
   // Clock rate in kHz; every count below derives from it
   localparam int unsigned CLK_KHZ = 10000;
   // Times in their printed units
   localparam int unsigned JAB_FAULT_MS = 20;
   localparam int unsigned UNJAB_MS = 500;
   localparam int unsigned HB_DELAY_NS = 1100;
   localparam int unsigned HB_LEN_NS = 1000;
   localparam int unsigned TX_GLITCH_NS = 20;
   localparam int unsigned TX_OFF_NS = 300;
   localparam int unsigned RX_OFF_NS = 200;
   localparam int unsigned RX_HOLD_NS = 1000;
   // Cycle counts: least times round up, longest times round down, never below one
   localparam int unsigned JAB_FAULT_CYC = JAB_FAULT_MS * CLK_KHZ;
   localparam int unsigned UNJAB_CYC = UNJAB_MS * CLK_KHZ;
   localparam int unsigned HB_DELAY_CYC = (HB_DELAY_NS * CLK_KHZ + 999999) / 1000000;
   localparam int unsigned HB_LEN_CYC = (HB_LEN_NS * CLK_KHZ) / 1000000;
   localparam int unsigned TX_GLITCH_RAW = (TX_GLITCH_NS * CLK_KHZ + 999999) / 1000000;
   localparam int unsigned TX_GLITCH_CYC = (TX_GLITCH_RAW < 1) ? 1 : TX_GLITCH_RAW;
   localparam int unsigned TX_OFF_CYC = (TX_OFF_NS * CLK_KHZ + 999999) / 1000000;
   localparam int unsigned RX_OFF_CYC = (RX_OFF_NS * CLK_KHZ + 999999) / 1000000;
   localparam int unsigned RX_HOLD_CYC = (RX_HOLD_NS * CLK_KHZ) / 1000000;
   // Counter widths
   localparam int unsigned LONG_W = 24;
   localparam int unsigned SHORT_W = 8;

   // Levels seen by the squelch and collision comparators
   typedef struct packed {
      logic tx_below_squelch;  // Transmit input below -175 mV
      logic rx_below_squelch;  // Filtered coax level below squelch threshold
      logic rx_data_high;      // Receive data at high level
      logic coll_detect;       // Data more negative than shield by threshold
   } jhc_levels_t;

   // Status seen by the station side
   typedef struct packed {
      logic tx_enabled;
      logic rx_active;
      logic jabber;
      logic heartbeat;
      logic collision;
   } jhc_status_t;

   typedef enum logic [1:0] {JAB_IDLE, JAB_FAULT, JAB_UNJAB} jhc_jab_state_t;
   typedef enum logic [1:0] {RX_OFF, RX_ON, RX_QUIET} jhc_rx_state_t;
endpackage

//--- src/jhc_top.sv
// Jabber timer, heartbeat, collision gating and squelch timing of the coax transceiver
//
// Overview of operation
// R01: Block transmit after 20 ms continuous activity
// R02: Collision output asserted throughout jabber fault
// R03: Hold transmitter off 500 ms after fault
// R04: Station keeps transmit idle during unjab
// R05: Heartbeat burst 1.1 us after transmit, 1 us
// R06: Heartbeat suppressed when enable input disables
// R07: Enable input low means heartbeat enabled
// R08: All jabber timing from 10 MHz clock
// R09: Collision pair carries oscillator when active
// R10: Collision pair idles at zero differential
// R11: Collision flagged from filtered level comparison
// R12: Transmit squelch ignores short or shallow pulses
// R13: Transmitter off after 300 ns above squelch
// R14: Receiver on when filtered level below squelch
// R15: Receiver quick off after 200 ns high
// R16: Stay off only if level rises within 1 us
// R17: Receive pair idles at zero differential
// R18: Activity counter clears on early transmit stop
`timescale 1ns/1ps
module jhc_top
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Comparator levels from the analog front end
   input wire jhc_pkg::jhc_levels_t levels,
   // Data from the station and the coax
   input wire logic tx_data,
   input wire logic rx_data,
   // Heartbeat enable pin: 0 is ground (enabled), 1 is negative supply (disabled)
   input wire logic heartbeat_enable,
   // Coax side
   output logic coax_transmit_out,
   output logic coax_transmit_en,
   // Station side pairs
   output logic rx_out_p,
   output logic rx_out_n,
   output logic collision_out_pair_p,
   output logic collision_out_pair_n,
   // Status
   output jhc_pkg::jhc_status_t status
);
   logic [jhc_pkg::SHORT_W-1:0] glitch_cnt_ff;
   logic tx_active_ff;
   logic [jhc_pkg::SHORT_W-1:0] txoff_cnt_ff;
   logic [jhc_pkg::LONG_W-1:0] jab_cnt_ff;
   jhc_pkg::jhc_jab_state_t jab_state_ff;
   logic hb_arm_ff;
   logic hb_burst_ff;
   logic hb_load;
   logic hb_expired;
   jhc_pkg::jhc_rx_state_t rx_state_ff;
   logic [jhc_pkg::SHORT_W-1:0] rxhigh_cnt_ff;
   logic [jhc_pkg::SHORT_W-1:0] rxhold_cnt_ff;
   logic tx_out_ff;
   logic tx_en_ff;
   logic rx_p_ff;
   logic rx_n_ff;
   logic coll_ff;
   logic tx_allowed;
   logic tx_end;
   logic coll_enable;

   // Saturating increment shared by the glitch, transmit-off and receive-high counters
   function automatic logic [jhc_pkg::SHORT_W-1:0] sat_inc(
      input logic [jhc_pkg::SHORT_W-1:0] v);
      sat_inc = (v == '1) ? v : v + 1'b1;
   endfunction

   // Transmit squelch: a negative pulse must last the glitch time before turn-on
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         glitch_cnt_ff <= '0;
      else if (levels.tx_below_squelch) // [R12]
         glitch_cnt_ff <= sat_inc(glitch_cnt_ff);
      else
         glitch_cnt_ff <= '0;
   end

   // Time spent above squelch while a packet is active
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         txoff_cnt_ff <= '0;
      else if (!tx_active_ff || levels.tx_below_squelch)
         txoff_cnt_ff <= '0;
      else
         txoff_cnt_ff <= sat_inc(txoff_cnt_ff);
   end

   // Packet ends once the line has sat above squelch for the off time
   assign tx_end = tx_active_ff && (txoff_cnt_ff >= jhc_pkg::SHORT_W'(jhc_pkg::TX_OFF_CYC)); // [R13]

   // Transmit activity flag
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         tx_active_ff <= 1'b0;
      else if (tx_end)
         tx_active_ff <= 1'b0; // [R13]
      else if (glitch_cnt_ff >= jhc_pkg::SHORT_W'(jhc_pkg::TX_GLITCH_CYC))
         tx_active_ff <= 1'b1; // [R12]
   end

   // Jabber state machine counts cycles of the 10 MHz clock
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         jab_state_ff <= jhc_pkg::JAB_IDLE;
         jab_cnt_ff <= '0;
      end
      else
      begin
         unique case (jab_state_ff)
            jhc_pkg::JAB_IDLE:
            begin
               if (!tx_active_ff)
                  jab_cnt_ff <= '0; // [R18]
               else if (jab_cnt_ff >= jhc_pkg::LONG_W'(jhc_pkg::JAB_FAULT_CYC)) // [R08]
               begin
                  jab_state_ff <= jhc_pkg::JAB_FAULT; // [R01]
                  jab_cnt_ff <= '0;
               end
               else
                  jab_cnt_ff <= jab_cnt_ff + 1'b1;
            end
            jhc_pkg::JAB_FAULT:
            begin
               // Fault lasts while the station keeps driving
               if (!tx_active_ff)
               begin
                  jab_state_ff <= jhc_pkg::JAB_UNJAB;
                  jab_cnt_ff <= '0;
               end
            end
            jhc_pkg::JAB_UNJAB:
            begin
               // The station must stay idle here; activity restarts nothing
               if (jab_cnt_ff >= jhc_pkg::LONG_W'(jhc_pkg::UNJAB_CYC - 1)) // [R03] [R04]
               begin
                  jab_state_ff <= jhc_pkg::JAB_IDLE;
                  jab_cnt_ff <= '0;
               end
               else
                  jab_cnt_ff <= jab_cnt_ff + 1'b1;
            end
         endcase
      end
   end

   // Only the idle jabber state lets the transmitter drive
   assign tx_allowed = (jab_state_ff == jhc_pkg::JAB_IDLE); // [R01] [R03]

   // Transmit drive follows station data only while allowed
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         tx_out_ff <= 1'b0;
         tx_en_ff <= 1'b0;
      end
      else
      begin
         tx_out_ff <= tx_allowed && tx_active_ff && tx_data; // [R01]
         // Enable spans the whole packet, not each data bit
         tx_en_ff <= tx_allowed && tx_active_ff; // [R01] [R13]
      end
   end

   // Registered drive and enable go straight to the coax pins
   assign coax_transmit_out = tx_out_ff;
   assign coax_transmit_en = tx_en_ff;

   // Heartbeat is armed by the end of a good transmission; pin low enables it
   assign hb_load = tx_end && tx_allowed && !heartbeat_enable; // [R06] [R07]

   jhc_down_timer #(.W(jhc_pkg::SHORT_W)) u_hb_timer
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(hb_load || (hb_arm_ff && hb_expired)),
      .load_val(hb_arm_ff ? jhc_pkg::SHORT_W'(jhc_pkg::HB_LEN_CYC)
                          : jhc_pkg::SHORT_W'(jhc_pkg::HB_DELAY_CYC)),
      .expired(hb_expired)
   );

   // Delay phase then burst phase of the heartbeat
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         hb_arm_ff <= 1'b0;
         hb_burst_ff <= 1'b0;
      end
      else if (hb_load)
      begin
         hb_arm_ff <= 1'b1; // [R05]
         hb_burst_ff <= 1'b0;
      end
      else if (hb_arm_ff && hb_expired)
      begin
         hb_arm_ff <= 1'b0;
         hb_burst_ff <= 1'b1; // [R05]
      end
      else if (hb_burst_ff && hb_expired)
         hb_burst_ff <= 1'b0;
   end

   // Collision comparator result registered
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         coll_ff <= 1'b0;
      else
         coll_ff <= levels.coll_detect; // [R11]
   end

   // Unjab adds no drive to the pair; of the jabber states only a live fault drives it
   assign coll_enable = coll_ff || (jab_state_ff == jhc_pkg::JAB_FAULT) || hb_burst_ff; // [R02] [R09]

   jhc_osc_gate u_coll_gate
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .enable(coll_enable), // [R09] [R10]
      .pair_p(collision_out_pair_p),
      .pair_n(collision_out_pair_n)
   );

   // Count time receive data sits high, for the quick turn-off
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         rxhigh_cnt_ff <= '0;
      else if (rx_data && rx_state_ff == jhc_pkg::RX_ON)
         rxhigh_cnt_ff <= sat_inc(rxhigh_cnt_ff);
      else
         rxhigh_cnt_ff <= '0;
   end

   // Receiver squelch state machine
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_state_ff <= jhc_pkg::RX_OFF;
         rxhold_cnt_ff <= '0;
      end
      else
      begin
         unique case (rx_state_ff)
            jhc_pkg::RX_OFF:
               if (levels.rx_below_squelch)
                  rx_state_ff <= jhc_pkg::RX_ON; // [R14]
            jhc_pkg::RX_ON:
               if (rxhigh_cnt_ff >= jhc_pkg::SHORT_W'(jhc_pkg::RX_OFF_CYC))
               begin
                  rx_state_ff <= jhc_pkg::RX_QUIET; // [R15]
                  rxhold_cnt_ff <= '0;
               end
            jhc_pkg::RX_QUIET:
            begin
               // Dribble bits are dropped here; a real packet keeps the level low
               if (!levels.rx_below_squelch)
                  rx_state_ff <= jhc_pkg::RX_OFF; // [R16]
               else if (rxhold_cnt_ff >= jhc_pkg::SHORT_W'(jhc_pkg::RX_HOLD_CYC - 1))
                  rx_state_ff <= jhc_pkg::RX_ON; // [R16]
               else
                  rxhold_cnt_ff <= rxhold_cnt_ff + 1'b1;
            end
         endcase
      end
   end

   // Receive pair carries data when on, both legs low otherwise
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rx_p_ff <= 1'b0;
         rx_n_ff <= 1'b0;
      end
      else
      begin
         rx_p_ff <= (rx_state_ff == jhc_pkg::RX_ON) && rx_data; // [R17]
         rx_n_ff <= (rx_state_ff == jhc_pkg::RX_ON) && !rx_data; // [R17]
      end
   end

   // Registered pair straight to the pins
   assign rx_out_p = rx_p_ff;
   assign rx_out_n = rx_n_ff;

   // Status view; jabber shows the live fault, unjab shows as transmit disabled
   assign status = '{
      tx_enabled: tx_allowed,
      rx_active: (rx_state_ff == jhc_pkg::RX_ON),
      jabber: (jab_state_ff == jhc_pkg::JAB_FAULT),
      heartbeat: hb_burst_ff,
      collision: coll_ff
   };
endmodule
